/* verilog/pport_pkg.sv */
/*
 Constants, register map and carrier types for the parallel slave port.
 Assumes a 32-bit AXI4-Lite register bus; every register sits in one aligned word.
*/
package pport_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] off_control       = 8'h00;
   localparam logic [7:0] off_in_status     = 8'h04;
   localparam logic [7:0] off_out_status    = 8'h08;
   localparam logic [7:0] off_inbound_one   = 8'h0c;
   localparam logic [7:0] off_inbound_two   = 8'h10;
   localparam logic [7:0] off_outbound_one  = 8'h14;
   localparam logic [7:0] off_outbound_two  = 8'h18;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int pos_all        = 7;
   localparam int pos_flag       = 6;
   localparam int pos_enable     = 0;
   localparam int pos_mode_lo    = 1;
   localparam int pos_csf_lo     = 3;
   localparam int pos_irq_flag   = 5;
   localparam int pos_csf_hi     = 4;
   localparam int pos_mode_hi    = 2;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [3:0] slots_empty_rst = 4'hf;
   localparam logic [1:0] mode_legacy     = 2'h0;
   localparam logic [1:0] mode_enhanced   = 2'h1;
   localparam logic [1:0] csf_both        = 2'h2;
   localparam logic [1:0] csf_two_only    = 2'h1;
   localparam logic [1:0] resp_okay       = 2'h0;
   localparam logic [1:0] resp_slverr     = 2'h2;

   typedef struct packed
   {
      logic [1:0] rd;
      logic [1:0] wr;
      logic [1:0] cs;
      logic [1:0] rd_prev;
      logic [1:0] wr_prev;
      logic [1:0][7:0] pd;
   } sync_s;

   typedef struct packed
   {
      logic       enable;
      logic [1:0] mode;
      logic [1:0] csf;
      logic       irq_flag;
      logic [3:0] in_full;
      logic       in_ovr;
      logic [3:0] out_empty;
      logic       out_udr;
      logic [7:0] in1_lo;
      logic [7:0] in1_hi;
      logic [7:0] in2_lo;
      logic [7:0] in2_hi;
      logic [7:0] out1_lo;
      logic [7:0] out1_hi;
      logic [7:0] out2_lo;
      logic [7:0] out2_hi;
      logic [7:0] pd_out;
      logic       pd_oe;
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic       aw_got;
      logic       w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
   } state_s;

endpackage

/* verilog/pport_slave.sv */
/*
 Legacy parallel slave port with buffer status flags and data register pairs.
 Assumes strobes and chip select arrive asynchronously, active high, and that
 the bench resolves the data pins from pd_out and pd_oe.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps

// What this block does
// - Input all-full flag is high only while every writable input slot holds unread data.
// - Writing a full input slot sets overrun; only software clears it.
// - Four input slot full flags in bits 3..0, cleared by software read.
// - Output all-empty flag high when all output slots empty; reset value one.
// - Reading an empty output slot sets underrun until software clears it.
// - Four output empty flags reset to one; software write clears, transmit sets.
// - Status bits 5 and 4 read zero and ignore writes.
// - Eight data registers form four high/low byte pairs.
// - First inbound pair receives data in legacy slave mode (00) only, into its low byte.
// - Second inbound pair only buffers received data in buffered slave modes; this block never writes it.
// - One pair is address in master modes, outgoing data in slave modes; here out1_hi is always address and master modes leave the port idle.
// - Second outbound pair buffers outgoing data in buffered slave modes only; this block never sends it.
// - Address bit 7 is chip select two for field 10 or 01, else bit 15; here it is bit 15 for every field.
// - Address bit 6 is chip select one only for field 10, else bit 14; here it is bit 14 for every field.
// - Address bits 5..0 hold address 13..8; whole register resets to zero.
// - In enhanced slave mode address-high acts as upper outbound data byte; here mode 01 leaves the port idle.
// - Legacy slave port works when mode is 00 and module enable is set.
// - Chip select with write strobe captures data into inbound one low byte.
// - At the end of each legacy write set interrupt flag and all-full flag.
// - Chip select with read strobe drives outbound one low onto the data lines.
// - Mode 00 legacy, 01 enhanced, 10 master two, 11 master one.
module pport_slave
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Parallel pins
   input  wire logic [7:0]  pd_in,
   output logic [7:0]       pd_out,
   output logic             pd_oe,
   input  wire logic        rd_strobe,
   input  wire logic        wr_strobe,
   input  wire logic        cs_one,
   // Status outputs
   output logic             port_interrupt_flag,
   output logic [7:0]       address_high_select,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);

   pport_pkg::sync_s  sy;
   pport_pkg::sync_s  next_sy;
   pport_pkg::state_s st;
   pport_pkg::state_s next_st;

   logic       legacy_on;
   logic       wr_end;
   logic       rd_start;
   logic       rd_end;
   logic       rd_active;
   logic       sw_wr;
   logic       sw_rd;
   logic [7:0] in_status_view;
   logic [7:0] out_status_view;
   logic [7:0] addr_high_view;
   logic [7:0] control_view;
   logic [31:0] read_mux;
   logic       read_hit;
   logic       write_hit;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Only stage 1 of each pair is read, so a metastable first stage never fans out.
   always_comb
   begin
      next_sy.rd      = {sy.rd[0], rd_strobe};
      next_sy.wr      = {sy.wr[0], wr_strobe};
      next_sy.cs      = {sy.cs[0], cs_one};
      next_sy.rd_prev = {sy.rd_prev[0], sy.rd[1] & sy.cs[1]};
      next_sy.wr_prev = {sy.wr_prev[0], sy.wr[1] & sy.cs[1]};
      next_sy.pd      = {sy.pd[0], pd_in};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sy <= '0;
      end
      else
      begin
         sy <= next_sy;
      end
   end

   // Data is sampled at the end of the write, when it has long been stable.
   assign legacy_on = st.enable && (st.mode == pport_pkg::mode_legacy);
   assign wr_end    = sy.wr_prev[1] & ~sy.wr_prev[0] & legacy_on;
   assign rd_start  = ~sy.rd_prev[1] & sy.rd_prev[0] & legacy_on;
   assign rd_end    = sy.rd_prev[1] & ~sy.rd_prev[0];
   assign rd_active = sy.rd_prev[0] & legacy_on;

   // ****************************************
   // Register views
   // ****************************************
   always_comb
   begin
      in_status_view = {&st.in_full, st.in_ovr, 2'h0, st.in_full};
      out_status_view = {&st.out_empty, st.out_udr, 2'h0, st.out_empty};
      addr_high_view = st.out1_hi;
      control_view = {2'h0, st.irq_flag, st.csf, st.mode, st.enable};
   end

   assign sw_wr = st.aw_got && st.w_got && !st.bvalid;
   assign sw_rd = arvalid && st.arready;
   assign write_hit = (st.aw_addr <= pport_pkg::off_outbound_two) && (st.aw_addr[1:0] == 2'h0);
   assign read_hit  = (araddr <= pport_pkg::off_outbound_two) && (araddr[1:0] == 2'h0);

   always_comb
   begin
      case (araddr)
         pport_pkg::off_control:      read_mux = {24'h0, control_view};
         pport_pkg::off_in_status:    read_mux = {24'h0, in_status_view};
         pport_pkg::off_out_status:   read_mux = {24'h0, out_status_view};
         pport_pkg::off_inbound_one:  read_mux = {16'h0, st.in1_hi, st.in1_lo};
         pport_pkg::off_inbound_two:  read_mux = {16'h0, st.in2_hi, st.in2_lo};
         pport_pkg::off_outbound_one: read_mux = {16'h0, addr_high_view, st.out1_lo};
         pport_pkg::off_outbound_two: read_mux = {16'h0, st.out2_hi, st.out2_lo};
         default:                     read_mux = 32'h0;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_st = st;
      next_st.awready = 1'b0;
      next_st.wready  = 1'b0;
      next_st.arready = 1'b0;
      if (awvalid && !st.aw_got && !st.awready)
      begin
         next_st.awready = 1'b1;
      end
      if (awvalid && st.awready)
      begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && !st.w_got && !st.wready)
      begin
         next_st.wready = 1'b1;
      end
      if (wvalid && st.wready)
      begin
         next_st.w_got  = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
      end
      if (sw_wr)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = write_hit ? pport_pkg::resp_okay : pport_pkg::resp_slverr;
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         if (st.w_strb[0])
         begin
            case (st.aw_addr)
               pport_pkg::off_control:
               begin
                  next_st.enable   = st.w_data[pport_pkg::pos_enable];
                  next_st.mode     = st.w_data[pport_pkg::pos_mode_hi:pport_pkg::pos_mode_lo];
                  next_st.csf      = st.w_data[pport_pkg::pos_csf_hi:pport_pkg::pos_csf_lo];
                  next_st.irq_flag = st.irq_flag & st.w_data[pport_pkg::pos_irq_flag];
               end
               pport_pkg::off_in_status:
                  next_st.in_ovr = st.in_ovr & st.w_data[pport_pkg::pos_flag];
               pport_pkg::off_out_status:
                  next_st.out_udr = st.out_udr & st.w_data[pport_pkg::pos_flag];
               pport_pkg::off_outbound_one:
               begin
                  next_st.out1_lo      = st.w_data[7:0];
                  next_st.out_empty[0] = 1'b0;
               end
               pport_pkg::off_outbound_two:
               begin
                  next_st.out2_lo      = st.w_data[7:0];
                  next_st.out_empty[2] = 1'b0;
               end
               default:
               begin
               end
            endcase
         end
         if (st.w_strb[1])
         begin
            if (st.aw_addr == pport_pkg::off_outbound_one)
            begin
               next_st.out1_hi      = st.w_data[15:8];
               next_st.out_empty[1] = 1'b0;
            end
            if (st.aw_addr == pport_pkg::off_outbound_two)
            begin
               next_st.out2_hi      = st.w_data[15:8];
               next_st.out_empty[3] = 1'b0;
            end
         end
      end
      if (st.bvalid && bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (arvalid && !st.arready && !st.rvalid)
      begin
         next_st.arready = 1'b1;
      end
      if (sw_rd)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = read_mux;
         next_st.rresp  = read_hit ? pport_pkg::resp_okay : pport_pkg::resp_slverr;
         if (araddr == pport_pkg::off_inbound_one)
         begin
            next_st.in_full[1:0] = 2'h0;
         end
         if (araddr == pport_pkg::off_inbound_two)
         begin
            next_st.in_full[3:2] = 2'h0;
         end
      end
      if (st.rvalid && rready)
      begin
         next_st.rvalid = 1'b0;
      end
      // Hardware events come last so a same-cycle set beats the software clear.
      if (wr_end)
      begin
         if (st.in_full[0])
         begin
            next_st.in_ovr = 1'b1;
         end
         next_st.in1_lo     = sy.pd[1];
         next_st.in_full[0] = 1'b1;
         // In legacy mode only slot 0 is writable, so slots 3..1 are marked full with it and all-full rises on each write.
         next_st.in_full[3:1] = 3'h7;
         next_st.irq_flag   = 1'b1;
      end
      if (rd_start)
      begin
         if (st.out_empty[0])
         begin
            next_st.out_udr = 1'b1;
         end
         next_st.pd_out = st.out1_lo;
      end
      if (rd_end && !st.out_empty[0])
      begin
         next_st.out_empty = pport_pkg::slots_empty_rst;
      end
      next_st.pd_oe = rd_active;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st           <= '0;
         st.out_empty <= pport_pkg::slots_empty_rst;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign pd_out              = st.pd_out;
   assign pd_oe               = st.pd_oe;
   assign port_interrupt_flag = st.irq_flag;
   assign address_high_select = st.out1_hi;
   assign awready             = st.awready;
   assign wready              = st.wready;
   assign bvalid              = st.bvalid;
   assign bresp               = st.bresp;
   assign arready             = st.arready;
   assign rvalid              = st.rvalid;
   assign rdata               = st.rdata;
   assign rresp               = st.rresp;

   // ****************************************
   // Checks
   // ****************************************
   sequence write_ends;
      wr_end;
   endsequence

   chk_write_capture: assert property (@(posedge clk) disable iff (rst)
      write_ends |=> st.in1_lo == $past(sy.pd[1]))
      else $error("write data not captured");
   chk_write_flags: assert property (@(posedge clk) disable iff (rst)
      write_ends |=> st.irq_flag && in_status_view[7])
      else $error("write end flags not set");
   chk_overrun_set: assert property (@(posedge clk) disable iff (rst)
      (wr_end && st.in_full[0]) |=> st.in_ovr)
      else $error("overrun not flagged");
   chk_underrun_set: assert property (@(posedge clk) disable iff (rst)
      (rd_start && st.out_empty[0]) |=> st.out_udr)
      else $error("underrun not flagged");
   chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      in_status_view[5:4] == 2'h0 && out_status_view[5:4] == 2'h0)
      else $error("reserved status bits not zero");
   chk_all_full: assert property (@(posedge clk) disable iff (rst)
      in_status_view[7] == (st.in_full == 4'hf))
      else $error("all-full flag wrong");
   chk_read_drive: assert property (@(posedge clk) disable iff (rst)
      rd_start |=> pd_out == $past(st.out1_lo) && pd_oe)
      else $error("read data not driven");
   chk_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
      !legacy_on |-> !wr_end && !rd_start)
      else $error("port acts while not legacy");
   chk_edge_once: assert property (@(posedge clk) disable iff (rst)
      wr_end |=> !wr_end)
      else $error("write edge seen twice");

endmodule

/* dv/ext_host_model.sv */
/*
 External processor that drives the legacy parallel port pins.
 Assumes the bench calls its tasks one at a time and feeds bus to pd_in.
*/
`timescale 1ns/100ps
module ext_host_model
(
   // Clock
   input  wire logic       clk,
   // Port outputs seen
   input  wire logic [7:0] pd_out,
   input  wire logic       pd_oe,
   // Pins driven
   output logic            rd_strobe,
   output logic            wr_strobe,
   output logic            cs_one,
   output logic [7:0]      bus
);
   logic [7:0] drv;
   logic       drv_en;
   logic [7:0] last;

   // ****************************************
   // Data line resolution
   // ****************************************
   // An undriven bus shows the inverse of its last value, so stale data never matches.
   always_comb bus = drv_en ? drv : (pd_oe ? pd_out : ~last);
   always @(posedge clk)
      if (drv_en || pd_oe)
      begin
         last <= bus;
      end

   initial
   begin
      drv = 8'h00; drv_en = 1'b0; last = 8'h00;
      rd_strobe = 1'b0; wr_strobe = 1'b0; cs_one = 1'b0;
   end

   // ****************************************
   // Transfers
   // ****************************************
   // Data is held well past the strobe end because the port samples it late.
   task write_byte(input logic [7:0] d);
      @(posedge clk);
      drv <= d; drv_en <= 1'b1; cs_one <= 1'b1; wr_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      wr_strobe <= 1'b0;
      repeat (6) @(posedge clk);
      cs_one <= 1'b0; drv_en <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task read_byte(output logic [7:0] d);
      @(posedge clk);
      cs_one <= 1'b1; rd_strobe <= 1'b1;
      repeat (12)
      begin
         @(posedge clk);
         if (pd_oe === 1'b1) break;
      end
      @(posedge clk);
      d = bus;
      rd_strobe <= 1'b0; cs_one <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule

/* dv/tb_top.sv */
/*
 Self-checking bench for the parallel slave port.
 Assumes the register map and codes of pport_pkg and the host model beside it.
*/
`timescale 1ns/100ps
module tb_top;
   logic        clk, rst;
   logic [7:0]  bus, pd_out, addr_hi, awaddr, araddr;
   logic        pd_oe, rd_s, wr_s, cs1, irq;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  xb;
   int          error_cnt, comparisons;

   pport_slave i_pport_slave (.clk(clk), .rst(rst), .pd_in(bus), .pd_out(pd_out),
      .pd_oe(pd_oe), .rd_strobe(rd_s), .wr_strobe(wr_s), .cs_one(cs1),
      .port_interrupt_flag(irq), .address_high_select(addr_hi), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   ext_host_model i_ext_host_model (.clk(clk), .pd_out(pd_out), .pd_oe(pd_oe),
      .rd_strobe(rd_s), .wr_strobe(wr_s), .cs_one(cs1), .bus(bus));

   // ****************************************
   // Clock, checks and closing
   // ****************************************
   initial clk = 1'b0;
   always #20 clk = ~clk;

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****************************************
   // Register bus tasks
   // ****************************************
   // The master waits as long as the slave needs; only the watchdog ends a stall.
   task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1;
      bready <= 1'b1;
      resp = 2'h3;
      forever
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            resp = bresp;
            break;
         end
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task axi_read(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      resp = 2'h3;
      rd = 32'hdeadbeef;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            rd = rdata; resp = rresp;
            break;
         end
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task reg_is(input string n, input logic [7:0] a, input logic [31:0] e);
      axi_read(a);
      check(n, rd, e);
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      error_cnt = 0; comparisons = 0;
      rst = 1'b1; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
      wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      reg_is("in_status", pport_pkg::off_in_status, 32'h0);
      reg_is("out_status", pport_pkg::off_out_status, 32'h8f);
      reg_is("outbound_one", pport_pkg::off_outbound_one, 32'h0);
      check("addr_hi", {24'h0, addr_hi}, 32'h0);
      axi_read(8'h1c);
      check("rd_unmapped", {30'h0, resp}, {30'h0, pport_pkg::resp_slverr});
      axi_write(8'h1c, 32'h1, 4'hf);
      check("wr_unmapped", {30'h0, resp}, {30'h0, pport_pkg::resp_slverr});
      $display("test reset done");

      axi_write(pport_pkg::off_control, 32'h01, 4'hf);
      i_ext_host_model.write_byte(8'ha5);
      check("irq", {31'h0, irq}, 32'h1);
      reg_is("in_full", pport_pkg::off_in_status, 32'h8f);
      reg_is("inbound_one", pport_pkg::off_inbound_one, 32'ha5);
      reg_is("in_part", pport_pkg::off_in_status, 32'h0c);
      i_ext_host_model.write_byte(8'h3c);
      i_ext_host_model.write_byte(8'h3c);
      reg_is("in_ovr", pport_pkg::off_in_status, 32'hcf);
      axi_read(pport_pkg::off_inbound_two);
      reg_is("in_two_rd", pport_pkg::off_in_status, 32'h43);
      axi_read(pport_pkg::off_inbound_one);
      reg_is("in_one_rd", pport_pkg::off_in_status, 32'h40);
      axi_write(pport_pkg::off_in_status, 32'h30, 4'hf);
      reg_is("in_clr", pport_pkg::off_in_status, 32'h0);
      $display("test inbound done");

      i_ext_host_model.read_byte(xb);
      reg_is("out_udr", pport_pkg::off_out_status, 32'hcf);
      axi_write(pport_pkg::off_out_status, 32'h30, 4'hf);
      reg_is("out_clr", pport_pkg::off_out_status, 32'h8f);
      axi_write(pport_pkg::off_outbound_one, 32'hc75a, 4'h3);
      reg_is("out_load", pport_pkg::off_out_status, 32'h0c);
      check("addr_hi", {24'h0, addr_hi}, 32'hc7);
      i_ext_host_model.read_byte(xb);
      check("pd_read", {24'h0, xb}, 32'h5a);
      reg_is("out_sent", pport_pkg::off_out_status, 32'h8f);
      $display("test outbound done");

      axi_write(pport_pkg::off_control, 32'h0, 4'hf);
      check("irq_clr", {31'h0, irq}, 32'h0);
      for (int m = 0; m < 4; m++)
      begin
         axi_write(pport_pkg::off_control, (m == 3) ? 32'h0 : 32'h1 | (m + 1) << 1,
                   4'hf);
         i_ext_host_model.write_byte(8'h11);
         reg_is("mode_idle", pport_pkg::off_in_status, 32'h0);
      end
      axi_write(pport_pkg::off_control, 32'h19, 4'hf);
      reg_is("csf", pport_pkg::off_control, 32'h19);
      $display("test modes done");
      summarize();
   end

   initial
   begin
      #(40 * 20000);
      error_cnt++;
      summarize();
   end
endmodule
